// *** common/cph_link.sv ***
// Multiplexed master/slave port link between host glue and processor
`timescale 1ns/1ns
interface cph_link;
    logic procClk;
    logic [7:0] hostBus;
    logic hostBusEn;
    logic [7:0] devBus;
    logic devBusEn;
    logic addrLatchEn;
    logic readStrobe;
    logic writeStrobe;
    logic dataStrobe;
    logic dirSelect;
    logic masterSel_n;
    logic slavePortSel_n;
    logic inFlag_n;
    logic outFlag_n;
    wire [7:0] busLevel = hostBusEn ? hostBus : (devBusEn ? devBus : 8'hff);

    modport host (
        output procClk, hostBus, hostBusEn, addrLatchEn, readStrobe, writeStrobe,
        output dataStrobe, dirSelect, masterSel_n, slavePortSel_n,
        input devBus, devBusEn, inFlag_n, outFlag_n, busLevel
    );
    modport device (
        input procClk, hostBus, hostBusEn, addrLatchEn, readStrobe, writeStrobe,
        input dataStrobe, dirSelect, masterSel_n, slavePortSel_n, busLevel,
        output devBus, devBusEn, inFlag_n, outFlag_n
    );
endinterface

// *** common/cph_pkg.sv ***
// Shared constants for the cipher processor link and its host glue
package cph_pkg;
    // Internal register select codes, latched from the bus
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h02;
    localparam logic [7:0] ADDR_MODE = 8'h06;
    // Operating mode fields
    localparam int MODE_CHAIN_LSB = 0;
    localparam logic [1:0] CHAIN_ECB = 2'h0;
    localparam logic [1:0] CHAIN_CBC = 2'h1;
    localparam logic [1:0] CHAIN_CFB = 2'h2;
    localparam int MODE_ENCRYPT_BIT = 2;
    localparam int MODE_DUAL_BIT = 3;
    localparam int MODE_DIRECT_BIT = 4;
    localparam int MODE_FAST_BIT = 5;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Commands
    localparam logic [7:0] CMD_START_DEC = 8'h40;
    localparam logic [7:0] CMD_START_ENC = 8'h41;
    localparam logic [7:0] CMD_STOP = 8'he0;
    localparam logic [7:0] CMD_LOAD_KEY = 8'h11;
    // Status fields of the processor
    localparam int STAT_IN_BIT = 0;
    localparam int STAT_OUT_BIT = 1;
    localparam int STAT_REFUSED_BIT = 5;
    localparam int STAT_PENDING_BIT = 6;
    localparam int STAT_SESSION_BIT = 7;
    // Block sizes in bytes
    localparam logic [3:0] BLOCK_BYTES = 4'h8;
    localparam logic [3:0] CFB_BYTES = 4'h1;
    // Timing in processor clocks
    localparam logic [4:0] ALG_CLOCKS = 5'd23;
    localparam logic [4:0] ALG_FAST_CLOCKS = 5'd18;
    localparam logic [2:0] RECOVERY_CLOCKS = 3'd5;
    localparam logic [4:0] INIT_CLOCKS = 5'd31;
    // Divider half periods in controller clocks
    localparam logic [2:0] DIV6_HALF = 3'd3;
    localparam logic [2:0] DIV4_HALF = 3'd2;
    // Host access phase lengths in controller clocks
    localparam logic [1:0] LATCH_CYCLES = 2'd2;
    localparam logic [1:0] STROBE_CYCLES = 2'd2;
    // Circulating bytes for feedback operation
    localparam logic [4:0] PRELOAD_OUT = 5'd8;
    localparam logic [4:0] PRELOAD_IN = 5'd1;
    localparam logic [4:0] PRELOAD_BYTES = PRELOAD_OUT + PRELOAD_IN;
    localparam logic [4:0] MAX_CIRC_BYTES = 5'd19;
    // Host register map
    localparam logic [3:0] HREG_CTRL = 4'h0;
    localparam logic [3:0] HREG_ADDR = 4'h1;
    localparam logic [3:0] HREG_WDATA = 4'h2;
    localparam logic [3:0] HREG_RDATA = 4'h3;
    localparam logic [3:0] HREG_STATUS = 4'h4;
    localparam logic [3:0] HREG_IRQ = 4'h5;
    localparam logic [3:0] HREG_MASK = 4'h6;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_READ_BIT = 1;
    localparam int CTRL_SLAVE_BIT = 2;
    localparam int CTRL_SKIP_BIT = 3;
    localparam int CTRL_FAST_BIT = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_IN_BIT = 1;
    localparam int IRQ_OUT_BIT = 2;
    localparam int IRQ_OVER_BIT = 3;
endpackage

// *** tb/cph_link_asserts.sv ***
// Concurrent checks on the link between host glue and processor
`timescale 1ns/1ns
module cph_link_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic procClk,
    input wire logic hostBusEn,
    input wire logic devBusEn,
    input wire logic addrLatchEn,
    input wire logic readStrobe,
    input wire logic writeStrobe,
    input wire logic dataStrobe,
    input wire logic dirSelect,
    input wire logic masterSel_n,
    input wire logic slavePortSel_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence latchPhase;
        addrLatchEn [*2] ##1 !addrLatchEn;
    endsequence
    sequence strobePhase;
        dataStrobe [*2] ##1 !dataStrobe;
    endsequence
    sequence highPhase;
        procClk [*2] ##[1:2] !procClk;
    endsequence
    sequence lowPhase;
        !procClk [*2] ##[1:2] procClk;
    endsequence
    strobe_or_a: assert property (dataStrobe == (readStrobe | writeStrobe))
        else $error("data strobe differs from read or write");
    dir_match_a: assert property (dataStrobe |-> dirSelect == readStrobe)
        else $error("direction select wrong during strobe");
    dir_setup_a: assert property ($rose(dataStrobe) |-> $stable(dirSelect))
        else $error("direction changed with strobe start");
    clk_high_a: assert property ($rose(procClk) |-> highPhase)
        else $error("processor clock high phase length wrong");
    clk_low_a: assert property ($fell(procClk) |-> lowPhase)
        else $error("processor clock low phase length wrong");
    latch_len_a: assert property ($rose(addrLatchEn) |-> latchPhase)
        else $error("address latch phase not two cycles");
    latch_drive_a: assert property (addrLatchEn |-> hostBusEn && !dataStrobe)
        else $error("address latch without bus drive or with strobe");
    strobe_len_a: assert property ($rose(dataStrobe) |-> strobePhase)
        else $error("strobe phase not two cycles");
    sel_access_a: assert property (dataStrobe |-> !(masterSel_n && slavePortSel_n))
        else $error("strobe without a port select");
    bus_clash_a: assert property (!(hostBusEn && devBusEn))
        else $error("both ends drive the bus");
    dev_drive_a: assert property (devBusEn |-> readStrobe && dirSelect)
        else $error("processor drives bus outside a read");
endmodule // cph_link_asserts

// *** tb/tb_top.sv ***
// Self-checking bench for host glue facing the cipher processor
`timescale 1ns/1ns
module tb_top;
    import cph_pkg::*;
    typedef struct {logic [7:0] wd; logic [7:0] ctrl;} row_s;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    logic irq;
    logic [7:0] modeView;
    logic sessionActive;
    logic [7:0] rd;
    logic [7:0] key [8];
    logic [7:0] dat [8];
    int failures = 0;
    int checks = 0;
    int n;
    int i;
    row_s rows [5];
    cph_link link ();
    cipher_host_glue i_cipher_host_glue (.clock(clock), .rst(rst), .link(link),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .irq(irq));
    cipher_processor i_cipher_processor (.clock(clock), .rst(rst), .link(link),
        .modeView(modeView), .sessionActive(sessionActive));
    cph_link_asserts i_cph_link_asserts (.clock(clock), .rst(rst), .procClk(link.procClk),
        .hostBusEn(link.hostBusEn), .devBusEn(link.devBusEn), .addrLatchEn(link.addrLatchEn),
        .readStrobe(link.readStrobe), .writeStrobe(link.writeStrobe),
        .dataStrobe(link.dataStrobe), .dirSelect(link.dirSelect),
        .masterSel_n(link.masterSel_n), .slavePortSel_n(link.slavePortSel_n));
    always #4 clock = ~clock;

    task automatic close_out();
        $display("counts: %0d checks, %0d failures", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic timeout(input string what);
        failures++;
        $display("wrong value %s: expected done, seen timeout", what);
        close_out();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rdreg(input logic [3:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        @(posedge clock);
        rd = regRdData;
    endtask
    // One link access: code, data, control flags; waits until the glue is idle
    task automatic acc(input logic [7:0] code, input logic [7:0] wd, input logic [7:0] ctrl);
        wr(HREG_ADDR, code);
        wr(HREG_WDATA, wd);
        wr(HREG_CTRL, ctrl | 8'h01);
        for (n = 0; n < 400; n++) begin
            rdreg(HREG_STATUS);
            if (rd[7] === 1'b0) break;
        end
        if (n == 400) timeout("busy");
    endtask

    initial begin
        rows = '{'{8'h01, 8'h00}, '{8'h02, 8'h10}, '{8'h20, 8'h00}, '{8'h06, 8'h10},
            '{8'h04, 8'h08}};
        repeat (20) @(posedge clock);
        check("reset in flag", 8'h01, {7'h0, link.inFlag_n});
        check("reset out flag", 8'h01, {7'h0, link.outFlag_n});
        check("reset irq", 8'h00, {7'h0, irq});
        check("reset mode", MODE_RESET, modeView);
        $display("reset test done");
        rst <= 1'b0;
        @(posedge clock);
        for (i = 0; i < 5; i++) begin
            acc(ADDR_MODE, rows[i].wd, rows[i].ctrl);
            acc(ADDR_MODE, 8'h00, rows[i].ctrl | 8'h02);
            rdreg(HREG_RDATA);
            check("mode read", rows[i].wd, rd);
            check("mode view", rows[i].wd, modeView);
        end
        $display("mode rows done");
        rdreg(HREG_IRQ);
        check("irq done bit", 8'h01, rd & 8'h01);
        wr(HREG_MASK, 8'h01);
        check("irq raised", 8'h01, {7'h0, irq});
        wr(HREG_IRQ, 8'h01);
        check("irq cleared", 8'h00, {7'h0, irq});
        wr(HREG_MASK, 8'h00);
        rdreg(4'hf);
        check("unmapped", 8'h00, rd);
        $display("register port test done");
        acc(ADDR_CMD, CMD_LOAD_KEY, 8'h00);
        for (i = 0; i < 8; i++) begin
            key[i] = {4'h3, 4'(i)};
            dat[i] = {4'(i), 4'h9};
            acc(ADDR_DATA, key[i], (i == 0) ? 8'h00 : 8'h08);
        end
        acc(ADDR_CMD, CMD_START_ENC, 8'h00);
        check("session on", 8'h01, {7'h0, sessionActive});
        acc(ADDR_MODE, 8'h05, 8'h00);
        check("mode locked", 8'h04, modeView);
        for (i = 0; i < 8; i++) begin
            acc(ADDR_DATA, dat[i], (i == 0) ? 8'h00 : 8'h08);
        end
        check("in flag recovery", 8'h01, {7'h0, link.inFlag_n});
        for (i = 0; i < 60 && link.outFlag_n !== 1'b0; i++) begin
            @(posedge link.procClk);
        end
        if (i == 60) timeout("out flag");
        // Output flag waits the algorithm clocks, then its own recovery; one extra rise is allowed
        n = i - ALG_CLOCKS - RECOVERY_CLOCKS;
        check("alg clocks", 8'h01, {7'h0, n == 0 || n == 1});
        for (i = 0; i < 8; i++) begin
            acc(ADDR_DATA, 8'h00, (i == 0) ? 8'h02 : 8'h0a);
            rdreg(HREG_RDATA);
            check("cipher byte", dat[i] ^ key[i], rd);
        end
        acc(ADDR_CMD, CMD_STOP, 8'h00);
        check("session off", 8'h00, {7'h0, sessionActive});
        $display("session test done");
        acc(ADDR_MODE, 8'h01 << MODE_DIRECT_BIT, 8'h00);
        acc(ADDR_CMD, CMD_LOAD_KEY, 8'h00);
        acc(ADDR_CMD, 8'h00, 8'h02);
        rdreg(HREG_RDATA);
        check("key refused", 8'h01 << STAT_REFUSED_BIT, rd & 8'h20);
        $display("streaming mode test done");
        // Dual port: writes only through the master select, reads only through the slave
        acc(ADDR_MODE, 8'h01 << MODE_DUAL_BIT, 8'h00);
        acc(ADDR_MODE, 8'h09, 8'h04);
        check("dual slave write", 8'h08, modeView);
        acc(ADDR_MODE, 8'h00, 8'h02);
        rdreg(HREG_RDATA);
        check("dual master read", 8'hff, rd);
        acc(ADDR_MODE, 8'h00, 8'h06);
        rdreg(HREG_RDATA);
        check("dual slave read", 8'h08, rd);
        $display("dual port test done");
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        check("mid reset mode", MODE_RESET, modeView);
        check("mid reset out flag", 8'h01, {7'h0, link.outFlag_n});
        check("mid reset irq", 8'h00, {7'h0, irq});
        rst <= 1'b0;
        @(posedge clock);
        rdreg(HREG_CTRL);
        check("mid reset ctrl", 8'h00, rd);
        $display("mid-run reset test done");
        close_out();
    end
endmodule // tb_top

// *** verilog/cipher_host_glue.sv ***
// Host glue: register port, access sequencer and clock divider
`timescale 1ns/1ns
module cipher_host_glue (
    input wire logic clock,
    input wire logic rst,
    cph_link.host link,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    output logic irq
);
    import cph_pkg::*;
    typedef enum logic [4:0] {
        IDLE = 5'b00001, LATCH = 5'b00010, SETUP = 5'b00100,
        STROBE = 5'b01000, INIT = 5'b10000
    } host_state_e;
    host_state_e state, next_state;
    logic [7:0] ctrl, devAddr, wrData, rdData;
    logic [3:0] irqStatus, irqMask;
    logic [1:0] phase;
    logic [4:0] initCount, circCount;
    logic inPrev, outPrev, procTick;

    proc_clock_div divider (
        .clock(clock), .rst(rst), .divideBy4(ctrl[CTRL_FAST_BIT]),
        .procClk(link.procClk), .riseTick(procTick)
    );

    wire busy = (state != IDLE);
    wire go = regWr & (regAddr == HREG_CTRL) & regWrData[CTRL_GO_BIT] & ~busy;
    wire opRead = ctrl[CTRL_READ_BIT];
    wire phaseEnd = (state == LATCH) ? (phase == LATCH_CYCLES - 2'd1)
                                     : (phase == STROBE_CYCLES - 2'd1);
    wire finish = (state == STROBE) & phaseEnd;
    wire dataAcc = finish & (devAddr == ADDR_DATA);
    wire overLimit = (circCount > MAX_CIRC_BYTES);
    wire [3:0] events = {overLimit, outPrev & ~link.outFlag_n,
                         inPrev & ~link.inFlag_n, finish};
    wire [3:0] irqClear = (regWr & regAddr == HREG_IRQ) ? regWrData[3:0] : 4'h0;
    wire active = (state == LATCH) | (state == SETUP) | (state == STROBE);

    always_comb begin
        next_state = state;
        unique case (state)
            IDLE: if (go) next_state = regWrData[CTRL_SKIP_BIT] ? SETUP : LATCH;
            LATCH: if (phaseEnd) next_state = SETUP;
            SETUP: next_state = STROBE;
            STROBE: if (phaseEnd) next_state = (devAddr == ADDR_CMD) ? INIT : IDLE;
            INIT: if (procTick & initCount == 5'd1) next_state = IDLE;
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= IDLE;
            phase <= 2'd0;
            initCount <= 5'd0;
        end else begin
            state <= next_state;
            phase <= (state != next_state) ? 2'd0 : phase + 2'd1;
            if (state == STROBE && next_state == INIT) initCount <= INIT_CLOCKS;
            else if (procTick && initCount != 5'd0) initCount <= initCount - 5'd1;
        end
    end

    // Software registers and interrupt status; a new event beats its clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl <= 8'h00;
            devAddr <= 8'h00;
            wrData <= 8'h00;
            rdData <= 8'h00;
            irqStatus <= 4'h0;
            irqMask <= 4'h0;
            regRdData <= 8'h00;
            inPrev <= 1'b1;
            outPrev <= 1'b1;
            circCount <= 5'd0;
        end else begin
            if (regWr && regAddr == HREG_CTRL && !busy) ctrl <= regWrData;
            if (regWr && regAddr == HREG_ADDR && !busy) devAddr <= regWrData;
            if (regWr && regAddr == HREG_WDATA && !busy) wrData <= regWrData;
            if (regWr && regAddr == HREG_MASK) irqMask <= regWrData[3:0];
            if (finish && opRead) rdData <= link.busLevel;
            if (dataAcc && !opRead) circCount <= circCount + 5'd1;
            else if (dataAcc && circCount != 5'd0) circCount <= circCount - 5'd1;
            irqStatus <= (irqStatus & ~irqClear) | events;
            inPrev <= link.inFlag_n;
            outPrev <= link.outFlag_n;
            if (regRd) begin
                unique case (regAddr)
                    HREG_CTRL: regRdData <= ctrl;
                    HREG_ADDR: regRdData <= devAddr;
                    HREG_WDATA: regRdData <= wrData;
                    HREG_RDATA: regRdData <= rdData;
                    HREG_STATUS: regRdData <= {busy, 3'h0, overLimit,
                        circCount >= PRELOAD_BYTES, ~link.outFlag_n, ~link.inFlag_n};
                    HREG_IRQ: regRdData <= {4'h0, irqStatus};
                    HREG_MASK: regRdData <= {4'h0, irqMask};
                    default: regRdData <= 8'h00;
                endcase
            end
        end
    end

    assign irq = |(irqStatus & irqMask);
    assign link.addrLatchEn = (state == LATCH);
    assign link.hostBus = (state == LATCH) ? devAddr : wrData;
    assign link.hostBusEn = (state == LATCH) | (active & ~opRead);
    assign link.dirSelect = opRead;
    assign link.readStrobe = (state == STROBE) & opRead;
    assign link.writeStrobe = (state == STROBE) & ~opRead;
    assign link.dataStrobe = link.readStrobe | link.writeStrobe;
    assign link.masterSel_n = ~(active & ~ctrl[CTRL_SLAVE_BIT]);
    assign link.slavePortSel_n = ~(active & ctrl[CTRL_SLAVE_BIT]);
endmodule // cipher_host_glue

// *** verilog/cipher_processor.sv ***
// Cipher processor end: register decode, flags and block pipeline
`timescale 1ns/1ns
module cipher_processor (
    input wire logic clock,
    input wire logic rst,
    cph_link.device link,
    output logic [7:0] modeView,
    output logic sessionActive
);
    import cph_pkg::*;
    logic [7:0] regAddr, mode, rdReg;
    logic clkPrev, strobePrev;
    logic session, keyLoading, refused;
    logic [63:0] key, inShift, outShift, algData;
    logic [3:0] inCount, outCount, keyCount;
    logic [4:0] algCount;
    logic algBusy;
    logic [2:0] inRecov, outRecov;

    // Processor clock rising edges and strobe rising edges, inputs are synchronous
    wire procTick = link.procClk & ~clkPrev;
    wire strobeRise = link.dataStrobe & ~strobePrev;

    wire masterSel = ~link.masterSel_n;
    wire slaveSel = ~link.slavePortSel_n;
    wire dualPort = mode[MODE_DUAL_BIT];
    wire direct = mode[MODE_DIRECT_BIT];
    wire isRead = link.dirSelect;
    wire feedback = (mode[MODE_CHAIN_LSB +: 2] == CHAIN_CFB);
    wire [3:0] blockLen = feedback ? CFB_BYTES : BLOCK_BYTES;
    wire [4:0] algLen = mode[MODE_FAST_BIT] ? ALG_FAST_CLOCKS : ALG_CLOCKS;

    // In dual port mode the master port only writes, the slave port only reads
    wire portOk = dualPort ? (isRead ? (slaveSel & ~masterSel) : (masterSel & ~slaveSel))
                           : masterSel;
    wire acc = strobeRise & portOk;

    wire selData = (regAddr == ADDR_DATA);
    wire selCmd = (regAddr == ADDR_CMD);
    wire selMode = (regAddr == ADDR_MODE);

    wire wrData = acc & ~isRead & selData;
    wire rdData = acc & isRead & selData;
    wire wrCmd = acc & ~isRead & selCmd;
    wire rdStat = acc & isRead & selCmd;
    wire wrMode = acc & ~isRead & selMode;
    wire rdMode = acc & isRead & selMode;

    wire startCmd = wrCmd & ((link.hostBus == CMD_START_ENC) | (link.hostBus == CMD_START_DEC));
    wire stopCmd = wrCmd & (link.hostBus == CMD_STOP);
    wire keyCmd = wrCmd & (link.hostBus == CMD_LOAD_KEY);
    wire keyRefused = keyCmd & direct;
    wire keyWrite = wrData & keyLoading;
    wire dataWrite = wrData & ~keyLoading & session;

    wire inReady = session & ~keyLoading & (inCount < blockLen) & (inRecov == 3'd0);
    wire outReady = session & (outCount != 4'd0) & (outRecov == 3'd0);
    wire algStart = session & ~algBusy & (inCount == blockLen) & (inRecov == 3'd0);
    wire algEnd = algBusy & (algCount == 5'd0) & (outCount == 4'd0) & (outRecov == 3'd0);
    wire dataRead = rdData & outReady;

    wire [63:0] blockIn = feedback ? {56'h0, inShift[7:0]} : inShift;
    wire [63:0] blockOut = feedback ? {algData[7:0], 56'h0} : algData;
    wire [7:0] status = {session, keyLoading, refused, 3'h0, outReady, inReady};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clkPrev <= 1'b0;
            strobePrev <= 1'b0;
            regAddr <= ADDR_DATA;
            mode <= MODE_RESET;
        end else begin
            clkPrev <= link.procClk;
            strobePrev <= link.dataStrobe;
            if (link.addrLatchEn) regAddr <= link.hostBus;
            if (wrMode && !session) mode <= link.hostBus;
        end
    end

    // Command handling and key loading
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            session <= 1'b0;
            keyLoading <= 1'b0;
            refused <= 1'b0;
            keyCount <= 4'd0;
            key <= 64'h0;
        end else begin
            if (startCmd) session <= 1'b1;
            else if (stopCmd) session <= 1'b0;
            if (stopCmd) refused <= 1'b0;
            else if (keyRefused) refused <= 1'b1;
            if (keyCmd && !direct && !session) begin
                keyLoading <= 1'b1;
                keyCount <= 4'd0;
            end else if (stopCmd) begin
                keyLoading <= 1'b0;
            end else if (keyWrite) begin
                key <= {key[55:0], link.hostBus};
                keyCount <= keyCount + 4'd1;
                if (keyCount == BLOCK_BYTES - 4'd1) keyLoading <= 1'b0;
            end
        end
    end

    // Input buffer, algorithm unit and output buffer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            inShift <= 64'h0;
            inCount <= 4'd0;
            inRecov <= 3'd0;
            algBusy <= 1'b0;
            algCount <= 5'd0;
            algData <= 64'h0;
            outShift <= 64'h0;
            outCount <= 4'd0;
            outRecov <= 3'd0;
        end else if (stopCmd) begin
            inCount <= 4'd0;
            inRecov <= 3'd0;
            algBusy <= 1'b0;
            algCount <= 5'd0;
            outCount <= 4'd0;
            outRecov <= 3'd0;
        end else begin
            if (dataWrite && inReady) begin
                inShift <= {inShift[55:0], link.hostBus};
                inCount <= inCount + 4'd1;
            end
            if (algStart) begin
                algData <= blockIn ^ key;
                algBusy <= 1'b1;
                algCount <= algLen;
                inCount <= 4'd0;
                inRecov <= RECOVERY_CLOCKS;
            end else if (procTick && inRecov != 3'd0) begin
                inRecov <= inRecov - 3'd1;
            end
            if (algBusy && procTick && algCount != 5'd0) algCount <= algCount - 5'd1;
            if (algEnd) begin
                algBusy <= 1'b0;
                outShift <= blockOut;
                outCount <= blockLen;
                outRecov <= RECOVERY_CLOCKS;
            end else begin
                if (procTick && outRecov != 3'd0) outRecov <= outRecov - 3'd1;
                if (dataRead) begin
                    outShift <= {outShift[55:0], 8'h00};
                    outCount <= outCount - 4'd1;
                end
            end
        end
    end

    // Read data for the bus, held from the cycle after the strobe edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdReg <= 8'h00;
        end else begin
            if (rdData) rdReg <= outReady ? outShift[63:56] : 8'h00;
            else if (rdStat) rdReg <= status;
            else if (rdMode) rdReg <= mode;
        end
    end

    assign link.devBus = rdReg;
    assign link.devBusEn = link.dataStrobe & isRead & portOk;
    assign link.inFlag_n = ~inReady;
    assign link.outFlag_n = ~outReady;
    assign modeView = mode;
    assign sessionActive = session;
endmodule // cipher_processor

// *** verilog/proc_clock_div.sv ***
// Divider that makes the processor clock from the controller clock
`timescale 1ns/1ns
module proc_clock_div (
    input wire logic clock,
    input wire logic rst,
    input wire logic divideBy4,
    output logic procClk,
    output logic riseTick
);
    import cph_pkg::*;
    logic [2:0] count;
    wire [2:0] half = divideBy4 ? DIV4_HALF : DIV6_HALF;
    wire flip = (count >= half - 3'd1);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= 3'd0;
            procClk <= 1'b0;
        end else begin
            count <= flip ? 3'd0 : count + 3'd1;
            procClk <= flip ? ~procClk : procClk;
        end
    end

    assign riseTick = flip & ~procClk;
endmodule // proc_clock_div
